// file: core/nvtc_consts.vh
`ifndef NVTC_CONSTS_VH
`define NVTC_CONSTS_VH

// Register offsets; printed offsets are not all multiples of four, so they are indices
`define NVTC_IDX_TIMER      8'hca
`define NVTC_IDX_SHORT      8'hcb
`define NVTC_IDX_CRC        8'hcf
`define NVTC_IDX_LIVE_WD    8'hd0
`define NVTC_IDX_STATUS     8'hd1

// Field positions in the timer settings register
`define NVTC_WD_MSB         7
`define NVTC_WD_LSB         4
`define NVTC_INIT_MSB       3
`define NVTC_INIT_LSB       0

// Reset values
`define NVTC_RST_TIMER      8'h00
`define NVTC_RST_SHORT      8'h00
`define NVTC_RST_CRC        8'h23

// Watchdog codes
`define NVTC_WD_OFF         4'h0
`define NVTC_WD_LAST_TIMED  4'hb

// Initialization timer code beyond which all mean the shortest time
`define NVTC_INIT_LAST      4'h9

// Clock rate and timeouts in microseconds
`define NVTC_CLK_MHZ        250
// Sized to the 20-bit duration buses so no bits are dropped silently
`define NVTC_T_200US        20'h000c8
`define NVTC_T_500US        20'h001f4
`define NVTC_T_1MS          20'h003e8
`define NVTC_T_2MS          20'h007d0
`define NVTC_T_5MS          20'h01388
`define NVTC_T_10MS         20'h02710
`define NVTC_T_20MS         20'h04e20
`define NVTC_T_50MS         20'h0c350
`define NVTC_T_100MS        20'h186a0
`define NVTC_T_200MS        20'h30d40
`define NVTC_T_500MS        20'h7a120
`define NVTC_T_50US         20'h00032
`define NVTC_T_100US        20'h00064

`endif

// file: core/nvtc_timeout_lut.v
`timescale 1ns/1ps
`include "nvtc_consts.vh"

// Decodes both stored timer codes into durations in microseconds
module nvtc_timeout_lut (
  // Codes
  input  wire [3:0]  wd_code,
  input  wire [3:0]  init_code,
  // Durations and watchdog flags
  output reg  [19:0] wd_us,
  output reg         wd_direct,
  output reg         wd_enabled,
  output reg  [19:0] init_us
);

  // Watchdog code map; twelve upward collapse to an immediate entry
  always @* begin
    wd_direct  = (wd_code > `NVTC_WD_LAST_TIMED);
    wd_enabled = (wd_code != `NVTC_WD_OFF);
    case (wd_code)
      4'h1:    wd_us = `NVTC_T_200US;
      4'h2:    wd_us = `NVTC_T_500US;
      4'h3:    wd_us = `NVTC_T_1MS;
      4'h4:    wd_us = `NVTC_T_2MS;
      4'h5:    wd_us = `NVTC_T_5MS;
      4'h6:    wd_us = `NVTC_T_10MS;
      4'h7:    wd_us = `NVTC_T_20MS;
      4'h8:    wd_us = `NVTC_T_50MS;
      4'h9:    wd_us = `NVTC_T_100MS;
      4'ha:    wd_us = `NVTC_T_200MS;
      4'hb:    wd_us = `NVTC_T_500MS;
      default: wd_us = 20'h00000;
    endcase
  end

  // Initialization code map; ten upward all mean the shortest time
  always @* begin
    case (init_code)
      4'h0:    init_us = 20'h00000;
      4'h1:    init_us = `NVTC_T_50MS;
      4'h2:    init_us = `NVTC_T_20MS;
      4'h3:    init_us = `NVTC_T_10MS;
      4'h4:    init_us = `NVTC_T_5MS;
      4'h5:    init_us = `NVTC_T_2MS;
      4'h6:    init_us = `NVTC_T_1MS;
      4'h7:    init_us = `NVTC_T_500US;
      4'h8:    init_us = `NVTC_T_200US;
      4'h9:    init_us = `NVTC_T_100US;
      default: init_us = `NVTC_T_50US;
    endcase
  end

endmodule // nvtc_timeout_lut

// file: core/nvtc_regs.v
`timescale 1ns/1ps
`include "nvtc_consts.vh"

module nvtc_regs (
  // Clock and reset
  input  wire        REF_CLK,
  input  wire        RSTN,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  input  wire [3:0]  PSTRB,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Live watchdog request from the control logic
  input  wire        LIVE_WD_LOAD,
  // Registered settings for the watchdog, initialization, short threshold and checksum machinery
  output reg  [3:0]  LIVE_WD_CODE,
  output reg         WD_ENABLED,
  output reg         WD_DIRECT_FAILSAFE,
  output reg  [19:0] WD_TIMEOUT_US,
  output reg  [19:0] INIT_TIMEOUT_US,
  output reg  [7:0]  SHORT_THRESHOLD,
  output reg  [7:0]  CHECKSUM_REF
);

  // Stored registers
  reg  [7:0]  timer_r;
  reg  [7:0]  short_r;
  reg  [7:0]  crc_r;
  reg  [3:0]  live_wd_r;
  reg         access_r;
  wire [19:0] wd_us;
  wire        wd_direct;
  wire        wd_enabled;
  wire [19:0] init_us;

  // Word address decode: index is the byte address divided by four
  function [2:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'b00)
        reg_sel = 3'd0;
      else if (addr[9:2] == `NVTC_IDX_TIMER)
        reg_sel = 3'd1;
      else if (addr[9:2] == `NVTC_IDX_SHORT)
        reg_sel = 3'd2;
      else if (addr[9:2] == `NVTC_IDX_CRC)
        reg_sel = 3'd3;
      else if (addr[9:2] == `NVTC_IDX_LIVE_WD)
        reg_sel = 3'd4;
      else if (addr[9:2] == `NVTC_IDX_STATUS)
        reg_sel = 3'd5;
      else
        reg_sel = 3'd0;
      if (addr[11:10] != 2'b00)
        reg_sel = 3'd0;
    end
  endfunction

  wire [2:0] sel       = reg_sel(PADDR);
  // Access phase completes in the second access cycle; ready is registered
  wire       acc_start = PSEL & PENABLE & ~access_r;
  // Writes land only at the edge where ready is seen, as the bus defines
  wire       wr_lo     = PSEL & PENABLE & PREADY & PWRITE & PSTRB[0];

  nvtc_timeout_lut u_lut (
    .wd_code    (timer_r[`NVTC_WD_MSB:`NVTC_WD_LSB]),
    .init_code  (timer_r[`NVTC_INIT_MSB:`NVTC_INIT_LSB]),
    .wd_us      (wd_us),
    .wd_direct  (wd_direct),
    .wd_enabled (wd_enabled),
    .init_us    (init_us)
  );

  // Register writes; only byte lane zero carries data
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      timer_r   <= `NVTC_RST_TIMER;
      short_r   <= `NVTC_RST_SHORT;
      crc_r     <= `NVTC_RST_CRC;
      live_wd_r <= 4'h0;
    end else begin
      if (wr_lo && sel == 3'd1)
        timer_r <= PWDATA[7:0];
      if (wr_lo && sel == 3'd2)
        short_r <= PWDATA[7:0];
      if (wr_lo && sel == 3'd3)
        crc_r <= PWDATA[7:0];
      // Live copy: a direct write wins over a reload from the stored default
      if (wr_lo && sel == 3'd4)
        live_wd_r <= PWDATA[3:0];
      else if (LIVE_WD_LOAD)
        live_wd_r <= timer_r[`NVTC_WD_MSB:`NVTC_WD_LSB];
    end
  end

  // APB answer, one access cycle with ready low, then ready
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      access_r <= 1'b0;
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
      PRDATA   <= 32'h00000000;
    end else begin
      access_r <= acc_start;
      PREADY   <= acc_start;
      PSLVERR  <= acc_start & (sel == 3'd0);
      if (acc_start && !PWRITE) begin
        case (sel)
          3'd1:    PRDATA <= {24'h000000, timer_r};
          3'd2:    PRDATA <= {24'h000000, short_r};
          3'd3:    PRDATA <= {24'h000000, crc_r};
          3'd4:    PRDATA <= {28'h0000000, live_wd_r};
          3'd5:    PRDATA <= {29'h00000000, wd_direct, wd_enabled, (init_us != 20'h00000)};
          default: PRDATA <= 32'h00000000;
        endcase
      end else begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  // Registered copies to the consuming logic
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LIVE_WD_CODE       <= 4'h0;
      WD_ENABLED         <= 1'b0;
      WD_DIRECT_FAILSAFE <= 1'b0;
      WD_TIMEOUT_US      <= 20'h00000;
      INIT_TIMEOUT_US    <= 20'h00000;
      SHORT_THRESHOLD    <= `NVTC_RST_SHORT;
      CHECKSUM_REF       <= `NVTC_RST_CRC;
    end else begin
      LIVE_WD_CODE       <= live_wd_r;
      WD_ENABLED         <= wd_enabled;
      WD_DIRECT_FAILSAFE <= wd_direct;
      WD_TIMEOUT_US      <= wd_us;
      INIT_TIMEOUT_US    <= init_us;
      SHORT_THRESHOLD    <= short_r;
      CHECKSUM_REF       <= crc_r;
    end
  end

endmodule // nvtc_regs

// file: verification/nvtc_regs_chk.sv
`timescale 1ns/1ps
module nvtc_regs_chk (
  // Clock, reset and bus
  input wire        REF_CLK,
  input wire        RSTN,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0]  PSTRB,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  // Settings
  input wire        LIVE_WD_LOAD,
  input wire [3:0]  LIVE_WD_CODE,
  input wire        WD_ENABLED,
  input wire        WD_DIRECT_FAILSAFE,
  input wire [19:0] WD_TIMEOUT_US,
  input wire [19:0] INIT_TIMEOUT_US,
  input wire [7:0]  SHORT_THRESHOLD,
  input wire [7:0]  CHECKSUM_REF
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // Write taken at this edge, strobe enabled
  wire wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
  property p_rdy; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  property p_off; !WD_ENABLED |-> WD_TIMEOUT_US == 0 && !WD_DIRECT_FAILSAFE; endproperty
  property p_tim; WD_ENABLED && !WD_DIRECT_FAILSAFE |-> WD_TIMEOUT_US inside
    {200, 500, 1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000, 500000}; endproperty
  property p_dir; WD_DIRECT_FAILSAFE |-> WD_ENABLED && WD_TIMEOUT_US == 0; endproperty
  property p_ini; INIT_TIMEOUT_US inside
    {0, 50, 100, 200, 500, 1000, 2000, 5000, 10000, 20000, 50000}; endproperty
  property p_sht; wr && PADDR == 12'h32c |=> ##1 SHORT_THRESHOLD == $past(PWDATA[7:0], 2);
  endproperty
  property p_crc; wr && PADDR == 12'h33c |=> ##1 CHECKSUM_REF == $past(PWDATA[7:0], 2);
  endproperty
  property p_rst; $rose(RSTN) |-> CHECKSUM_REF == 8'h23 && SHORT_THRESHOLD == 0; endproperty
  // A bus write in the same cycle wins, so it is left out
  property p_ld; LIVE_WD_LOAD && !(PSEL && PWRITE) |=> ##1
    (LIVE_WD_CODE == 0) == !WD_ENABLED && (LIVE_WD_CODE >= 12) == WD_DIRECT_FAILSAFE;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after access");
  a_off: assert property (p_off) else $error("disabled watchdog has timeout");
  a_tim: assert property (p_tim) else $error("bad watchdog timeout");
  a_dir: assert property (p_dir) else $error("direct entry with timeout");
  a_ini: assert property (p_ini) else $error("bad init timeout");
  a_sht: assert property (p_sht) else $error("threshold not written");
  a_crc: assert property (p_crc) else $error("checksum ref not written");
  a_rst: assert property (p_rst) else $error("bad reset value");
  a_ld: assert property (p_ld) else $error("live code not loaded");
  c_wr: cover property (wr && PADDR == 12'h32c);
  c_err: cover property (PREADY && PSLVERR);
  c_dir: cover property (WD_DIRECT_FAILSAFE);
endmodule // nvtc_regs_chk
bind nvtc_regs nvtc_regs_chk u_chk (.*);

// file: verification/test_nv_timer_crc_config_regs.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module test_nv_timer_crc_config_regs;
  logic        REF_CLK, RSTN, PSEL, PENABLE, PWRITE, LIVE_WD_LOAD, PREADY, PSLVERR, er;
  logic        WD_ENABLED, WD_DIRECT_FAILSAFE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0]  PSTRB, LIVE_WD_CODE;
  logic [19:0] WD_TIMEOUT_US, INIT_TIMEOUT_US;
  logic [7:0]  SHORT_THRESHOLD, CHECKSUM_REF;
  int          bad_count, checks_done;
  int wd_t[16] = '{0, 200, 500, 1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000,
                   500000, 0, 0, 0, 0};
  int in_t[16] = '{0, 50000, 20000, 10000, 5000, 2000, 1000, 500, 200, 100, 50, 50, 50,
                   50, 50, 50};
  nvtc_regs dut_u (.*);
  always #2 REF_CLK = ~REF_CLK;
  // One bus transfer; an idle cycle first keeps each signal to one update per edge
  task apb(input bit w, input [11:0] a, input [31:0] d, input [3:0] s);
    @(posedge REF_CLK);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d; PSTRB <= s;
    @(posedge REF_CLK);
    PENABLE <= 1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1);
    rd = PRDATA; er = PSLVERR; PSEL <= 0; PENABLE <= 0;
  endtask
  task t_rst;
    apb(0, 12'h328, 0, 4'hf); `CHK(rd, 32'h0)
    apb(0, 12'h32c, 0, 4'hf); `CHK(rd, 32'h0)
    apb(0, 12'h33c, 0, 4'hf); `CHK(rd, 32'h23)
    `CHK(CHECKSUM_REF, 8'h23)
    $display("reset values done");
  endtask
  // Both fields swept together: watchdog code i, init code 15-i
  task t_wd;
    for (int i = 0; i < 16; i++) begin
      apb(1, 12'h328, {24'h0, i[3:0], ~i[3:0]}, 4'hf);
      // Decoded copies follow one cycle after the write edge
      @(posedge REF_CLK);
      @(negedge REF_CLK);
      `CHK(WD_TIMEOUT_US, 20'(wd_t[i]))
      `CHK(WD_ENABLED, i != 0)
      `CHK(WD_DIRECT_FAILSAFE, i > 11)
      `CHK(INIT_TIMEOUT_US, 20'(in_t[15 - i]))
      apb(0, 12'h328, 0, 4'hf); `CHK(rd, {24'h0, i[3:0], ~i[3:0]})
      apb(0, 12'h344, 0, 4'hf); `CHK(rd, {29'h0, i > 11, i != 0, i != 15})
    end
    $display("timer codes done");
  endtask
  task t_rw;
    apb(1, 12'h32c, 32'hffff_ffa5, 4'hf); apb(0, 12'h32c, 0, 4'hf);
    `CHK(rd, 32'ha5)
    `CHK(SHORT_THRESHOLD, 8'ha5)
    apb(1, 12'h32c, 32'h5a, 4'h0); apb(0, 12'h32c, 0, 4'hf);
    `CHK(rd, 32'ha5)
    // Checksum written after the threshold; t_live writes the timer field again later
    apb(1, 12'h33c, 32'h9c, 4'hf); apb(0, 12'h33c, 0, 4'hf);
    `CHK(rd, 32'h9c)
    `CHK(CHECKSUM_REF, 8'h9c)
    apb(1, 12'h330, 32'h1, 4'hf); `CHK(er, 1'b1)
    apb(0, 12'h330, 0, 4'hf); `CHK(rd, 32'h0)
    $display("read write done");
  endtask
  task t_live;
    apb(1, 12'h328, 32'h70, 4'hf);
    @(posedge REF_CLK) LIVE_WD_LOAD <= 1;
    @(posedge REF_CLK) LIVE_WD_LOAD <= 0;
    repeat (2) @(negedge REF_CLK);
    `CHK(LIVE_WD_CODE, 4'h7)
    apb(0, 12'h340, 0, 4'hf); `CHK(rd, 32'h7)
    // Second reset in mid-run must bring the defaults back
    @(posedge REF_CLK) RSTN <= 0;
    repeat (2) @(posedge REF_CLK);
    RSTN <= 1;
    $display("live load done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    REF_CLK = 0; RSTN = 0; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0;
    PWDATA = 0; PSTRB = 0; LIVE_WD_LOAD = 0;
    repeat (8) @(posedge REF_CLK);
    RSTN <= 1;
    t_rst; t_wd; t_rw; t_live; t_rst;
    report_and_stop;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
endmodule // test_nv_timer_crc_config_regs
